// *** rtl/dix_map.svh ***
/*
 * Holds the address map, field positions, vector codes and reset values of
 * the interrupt expansion block.
 * Assumes it is included by its bare name before any use of its macros.
 */
`ifndef DIX_MAP_SVH
`define DIX_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DIX_ADDR_MASK 16'h0004
`define DIX_ADDR_FLAGS 16'h0006
`define DIX_ADDR_REQ0 16'h7010
`define DIX_ADDR_REQ1 16'h7011
`define DIX_ADDR_ACK0 16'h7014
`define DIX_ADDR_ACK1 16'h7015
`define DIX_ADDR_EN0 16'h7018
`define DIX_ADDR_EN1 16'h7019
`define DIX_ADDR_MODE 16'h701a
`define DIX_ADDR_VEC 16'h701e

// ----------------------------------------------------------------------
// Vector locations and reset values
// ----------------------------------------------------------------------
`define DIX_VEC_TRAP 6'h22
`define DIX_VEC_NMI 6'h24
`define DIX_VEC_EMU 6'h26
`define DIX_VEC_NONE 16'h0000
`define DIX_RST_16 16'h0000
`define DIX_RST_32 32'h0000_0000
`define DIX_RST_LINES 6'h00

// ----------------------------------------------------------------------
// Mode bits: set selects the low-priority line for that source
// ----------------------------------------------------------------------
`define DIX_MODE_CONV 0
`define DIX_MODE_SERIAL 1
`define DIX_MODE_EXT 2

// ----------------------------------------------------------------------
// Group membership over the 32 request bits (request set 1 in bits 31:16)
// ----------------------------------------------------------------------
`define DIX_GRP1 32'h0000_007f
`define DIX_GRP2 32'h0000_fe00
`define DIX_GRP3 32'h000f_0000
`define DIX_GRP4 32'h0010_0000
`define DIX_GRP5 32'h0300_0000
`define DIX_GRP6 32'h1c00_0000

`endif

// *** rtl/dix_pkg.sv ***
/*
 * Holds the types shared by the interrupt expansion block.
 * Assumes nothing of its surroundings.
 */
package dix_pkg;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dix_bus_t;

    typedef struct packed {
        logic soft_vector_instruction;
        logic nmi;
        logic trap;
        logic [5:0] vec;
    } dix_soft_t;

    typedef struct packed {
        logic valid;
        logic [2:0] line;
    } dix_ack_t;

    typedef struct packed {
        logic req;
        logic [5:0] vec;
    } dix_branch_t;

    typedef struct packed {
        logic conv;
        logic rx;
        logic tx;
        logic [2:0] cmp;
        logic [3:0] tmr_a;
        logic [3:0] tmr_b;
        logic cap;
    } dix_periph_t;

endpackage : dix_pkg

// *** rtl/dix_irq_expander.sv ***
/*
 * Holds the peripheral interrupt expansion unit with its core mask and flag
 * registers, software interrupt decode, global mask and illegal-access
 * detection.
 * Assumes the core bus, peripherals and watchdog run on clk, and the three
 * interrupt pins are asynchronous.
 */
`timescale 1ns/1ps
`include "dix_map.svh"

module dix_irq_expander
    import dix_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wdog_expire,
    input wire dix_bus_t bus,
    output logic [15:0] bus_rdata_r,
    input wire dix_soft_t soft_req,
    input wire logic emu_trap_sel,
    input wire logic gm_set,
    input wire logic gm_clear,
    input wire dix_ack_t core_ack,
    input wire logic power_fault_input,
    input wire logic external_request_a,
    input wire logic external_request_b,
    input wire dix_periph_t periph,
    output logic cpu_reset_r,
    output logic [5:0] core_line_r,
    output logic [5:0] cpu_int_r,
    output dix_branch_t branch_r,
    output logic global_mask_bit_r
);

    // ------------------------------------------------------------------
    // Lookup functions
    // ------------------------------------------------------------------
    function automatic logic [15:0] src_vector(input logic [4:0] idx);
        logic [15:0] v;
        v = `DIX_VEC_NONE;
        unique case (idx)
            5'h00: v = 16'h0020;
            5'h01: v = 16'h0004;
            5'h02: v = 16'h0001;
            5'h03: v = 16'h0011;
            5'h05: v = 16'h0006;
            5'h06: v = 16'h0007;
            5'h09: v = 16'h0021;
            5'h0a: v = 16'h0022;
            5'h0b: v = 16'h0023;
            5'h0c: v = 16'h0027;
            5'h0d: v = 16'h0028;
            5'h0e: v = 16'h0029;
            5'h0f: v = 16'h002a;
            5'h10: v = 16'h002b;
            5'h11: v = 16'h002c;
            5'h12: v = 16'h002d;
            5'h13: v = 16'h002e;
            5'h14: v = 16'h0033;
            5'h18: v = 16'h0006;
            5'h19: v = 16'h0007;
            5'h1a: v = 16'h0004;
            5'h1b: v = 16'h0001;
            5'h1c: v = 16'h0011;
            default: v = `DIX_VEC_NONE;
        endcase
        return v;
    endfunction : src_vector

    // Only regions marked illegal answer true; reserved regions stay quiet.
    function automatic logic is_illegal(input logic [15:0] a);
        logic hit;
        hit = 1'b0;
        if ((a >= 16'h0080 && a <= 16'h00ff) ||
            (a >= 16'h0500 && a <= 16'h07ff) ||
            (a >= 16'h0a00 && a <= 16'h6fff) ||
            (a >= 16'h7030 && a <= 16'h703f) ||
            (a >= 16'h7060 && a <= 16'h706f) ||
            (a >= 16'h7080 && a <= 16'h708f) ||
            (a >= 16'h70c0 && a <= 16'h70ff) ||
            (a >= 16'h7440 && a <= 16'h74ff) ||
            (a >= 16'h7540 && a <= 16'h77ef) ||
            (a >= 16'h7800))
            hit = 1'b1;
        return hit;
    endfunction : is_illegal

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] pin_lvl_r;
    logic [2:0] pin_lvl_nxt;
    logic [2:0] pin_rise;

    assign pin_raw = {external_request_b, external_request_a,
                      power_fault_input};

    // A change counts only once the second and third stages agree.
    always_comb
    begin
        pin_lvl_nxt = pin_lvl_r;
        for (int i = 0; i < 3; i++)
        begin
            if (sync2_r[i] == sync3_r[i])
                pin_lvl_nxt[i] = sync3_r[i];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
            pin_lvl_r <= 3'h0;
        end
        else
        begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_lvl_r <= pin_lvl_nxt;
        end
    end

    assign pin_rise = pin_lvl_nxt & ~pin_lvl_r;

    // ------------------------------------------------------------------
    // Request mapping onto groups
    // ------------------------------------------------------------------
    logic [15:0] mask_r;
    logic [15:0] mask_nxt;
    logic [15:0] flags_r;
    logic [15:0] flags_nxt;
    logic [31:0] pend_r;
    logic [31:0] pend_nxt;
    logic [31:0] ackf_r;
    logic [31:0] ackf_nxt;
    logic [31:0] en_r;
    logic [31:0] en_nxt;
    logic [2:0] mode_r;
    logic [2:0] mode_nxt;
    logic [15:0] vec_r;
    logic [15:0] vec_nxt;
    logic [31:0] raw_set;
    logic [31:0] set;
    logic [5:0] grp_pend;
    logic [31:0] grp_sel;
    logic [31:0] ack_sel;
    logic [4:0] ack_idx;
    logic ack_hit;
    logic lo_conv;
    logic lo_ser;
    logic lo_ext;

    assign lo_conv = mode_r[`DIX_MODE_CONV];
    assign lo_ser = mode_r[`DIX_MODE_SERIAL];
    assign lo_ext = mode_r[`DIX_MODE_EXT];

    always_comb
    begin
        raw_set = `DIX_RST_32;
        raw_set[0] = pin_rise[0];
        raw_set[1] = periph.conv & ~lo_conv;
        raw_set[2] = pin_rise[1] & ~lo_ext;
        raw_set[3] = pin_rise[2] & ~lo_ext;
        raw_set[5] = periph.rx & ~lo_ser;
        raw_set[6] = periph.tx & ~lo_ser;
        raw_set[11:9] = periph.cmp;
        raw_set[15:12] = periph.tmr_a;
        raw_set[19:16] = periph.tmr_b;
        raw_set[20] = periph.cap;
        raw_set[24] = periph.rx & lo_ser;
        raw_set[25] = periph.tx & lo_ser;
        raw_set[26] = periph.conv & lo_conv;
        raw_set[27] = pin_rise[1] & lo_ext;
        raw_set[28] = pin_rise[2] & lo_ext;
    end

    assign set = raw_set & en_r;

    always_comb
    begin
        grp_pend[0] = |(pend_r & `DIX_GRP1);
        grp_pend[1] = |(pend_r & `DIX_GRP2);
        grp_pend[2] = |(pend_r & `DIX_GRP3);
        grp_pend[3] = |(pend_r & `DIX_GRP4);
        grp_pend[4] = |(pend_r & `DIX_GRP5);
        grp_pend[5] = |(pend_r & `DIX_GRP6);
        unique case (core_ack.line)
            3'h1: grp_sel = `DIX_GRP1;
            3'h2: grp_sel = `DIX_GRP2;
            3'h3: grp_sel = `DIX_GRP3;
            3'h4: grp_sel = `DIX_GRP4;
            3'h5: grp_sel = `DIX_GRP5;
            3'h6: grp_sel = `DIX_GRP6;
            default: grp_sel = `DIX_RST_32;
        endcase
    end

    always_comb
    begin
        ack_idx = 5'h00;
        ack_hit = 1'b0;
        ack_sel = `DIX_RST_32;
        for (int i = 31; i >= 0; i--)
        begin
            if (pend_r[i] & grp_sel[i])
            begin
                ack_idx = 5'(i);
                ack_hit = 1'b1;
            end
        end
        if (core_ack.valid && ack_hit)
            ack_sel[ack_idx] = 1'b1;
    end

    // ------------------------------------------------------------------
    // Register file and software interrupts
    // ------------------------------------------------------------------
    logic acc;
    logic wr_req0;
    logic wr_req1;
    logic wr_ack0;
    logic wr_ack1;
    logic [15:0] rdata_nxt;
    logic [5:0] ack_line_bit;
    logic gm_nxt;
    logic [5:0] core_line_nxt;
    logic [5:0] cpu_int_nxt;
    dix_branch_t branch_nxt;

    assign acc = bus.rd | bus.wr;
    assign wr_req0 = bus.wr && bus.addr == `DIX_ADDR_REQ0;
    assign wr_req1 = bus.wr && bus.addr == `DIX_ADDR_REQ1;
    assign wr_ack0 = bus.wr && bus.addr == `DIX_ADDR_ACK0;
    assign wr_ack1 = bus.wr && bus.addr == `DIX_ADDR_ACK1;
    assign ack_line_bit = (core_ack.valid && ack_hit) ?
                          grp_pend & 6'(1 << (core_ack.line - 3'h1)) :
                          `DIX_RST_LINES;

    always_comb
    begin
        mask_nxt = mask_r;
        en_nxt = en_r;
        mode_nxt = mode_r;
        vec_nxt = vec_r;
        gm_nxt = global_mask_bit_r;
        branch_nxt = '0;
        rdata_nxt = `DIX_RST_16;
        if (bus.wr && bus.addr == `DIX_ADDR_MASK)
            mask_nxt = bus.wdata;
        if (bus.wr && bus.addr == `DIX_ADDR_EN0)
            en_nxt[15:0] = bus.wdata;
        if (bus.wr && bus.addr == `DIX_ADDR_EN1)
            en_nxt[31:16] = bus.wdata;
        if (bus.wr && bus.addr == `DIX_ADDR_MODE)
            mode_nxt = bus.wdata[2:0];
        // Software clears by writing ones; a new event in the same cycle
        // wins so it is never lost.
        pend_nxt = (pend_r & ~({bus.wdata & {16{wr_req1}},
                                bus.wdata & {16{wr_req0}}} | ack_sel))
                   | set;
        ackf_nxt = (ackf_r & ~{bus.wdata & {16{wr_ack1}},
                               bus.wdata & {16{wr_ack0}}}) | ack_sel;
        flags_nxt = flags_r & ~({10'h000, ack_line_bit});
        if (bus.wr && bus.addr == `DIX_ADDR_FLAGS)
            flags_nxt = flags_nxt & ~bus.wdata;
        // The acknowledged line drops for one cycle, or a served flag
        // would be set again from the old pending state and never clear.
        flags_nxt[5:0] = flags_nxt[5:0] | (grp_pend & ~ack_line_bit);
        if (core_ack.valid)
        begin
            vec_nxt = ack_hit ? src_vector(ack_idx) : `DIX_VEC_NONE;
            gm_nxt = 1'b1;
        end
        if (gm_clear)
            gm_nxt = 1'b0;
        if (gm_set)
            gm_nxt = 1'b1;
        if (acc && is_illegal(bus.addr))
        begin
            branch_nxt.req = 1'b1;
            branch_nxt.vec = `DIX_VEC_NMI;
            gm_nxt = 1'b1;
        end
        else if (soft_req.trap)
        begin
            branch_nxt.req = 1'b1;
            branch_nxt.vec = emu_trap_sel ? `DIX_VEC_EMU : `DIX_VEC_TRAP;
        end
        else if (soft_req.nmi)
        begin
            branch_nxt.req = 1'b1;
            branch_nxt.vec = `DIX_VEC_NMI;
            gm_nxt = 1'b1;
        end
        else if (soft_req.soft_vector_instruction)
        begin
            branch_nxt.req = 1'b1;
            branch_nxt.vec = soft_req.vec;
            gm_nxt = 1'b1;
        end
        if (bus.rd)
        begin
            unique case (bus.addr)
                `DIX_ADDR_MASK: rdata_nxt = mask_r;
                `DIX_ADDR_FLAGS: rdata_nxt = flags_r;
                `DIX_ADDR_REQ0: rdata_nxt = pend_r[15:0];
                `DIX_ADDR_REQ1: rdata_nxt = pend_r[31:16];
                `DIX_ADDR_ACK0: rdata_nxt = ackf_r[15:0];
                `DIX_ADDR_ACK1: rdata_nxt = ackf_r[31:16];
                `DIX_ADDR_EN0: rdata_nxt = en_r[15:0];
                `DIX_ADDR_EN1: rdata_nxt = en_r[31:16];
                `DIX_ADDR_MODE: rdata_nxt = {13'h0000, mode_r};
                `DIX_ADDR_VEC: rdata_nxt = vec_r;
                default: rdata_nxt = `DIX_RST_16;
            endcase
        end
        core_line_nxt = grp_pend;
        cpu_int_nxt = flags_nxt[5:0] & mask_nxt[5:0] & {6{~gm_nxt}};
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    // The watchdog is treated like the pin: it loads the reset value of every register below
    // on the same edge, so no half-reset state can reach the core; it leaves the pin synchronisers running.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_reset_r <= 1'b1;
            global_mask_bit_r <= 1'b1;
            mask_r <= `DIX_RST_16;
            flags_r <= `DIX_RST_16;
            pend_r <= `DIX_RST_32;
            ackf_r <= `DIX_RST_32;
            en_r <= `DIX_RST_32;
            mode_r <= 3'h0;
            vec_r <= `DIX_RST_16;
            branch_r <= '0;
            bus_rdata_r <= `DIX_RST_16;
            core_line_r <= `DIX_RST_LINES;
            cpu_int_r <= `DIX_RST_LINES;
        end
        else if (wdog_expire)
        begin
            cpu_reset_r <= 1'b1;
            global_mask_bit_r <= 1'b1;
            mask_r <= `DIX_RST_16;
            flags_r <= `DIX_RST_16;
            pend_r <= `DIX_RST_32;
            ackf_r <= `DIX_RST_32;
            en_r <= `DIX_RST_32;
            mode_r <= 3'h0;
            vec_r <= `DIX_RST_16;
            branch_r <= '0;
            bus_rdata_r <= `DIX_RST_16;
            core_line_r <= `DIX_RST_LINES;
            cpu_int_r <= `DIX_RST_LINES;
        end
        else
        begin
            cpu_reset_r <= 1'b0;
            global_mask_bit_r <= gm_nxt;
            mask_r <= mask_nxt;
            flags_r <= flags_nxt;
            pend_r <= pend_nxt;
            ackf_r <= ackf_nxt;
            en_r <= en_nxt;
            mode_r <= mode_nxt;
            vec_r <= vec_nxt;
            branch_r <= branch_nxt;
            bus_rdata_r <= rdata_nxt;
            core_line_r <= core_line_nxt;
            cpu_int_r <= cpu_int_nxt;
        end
    end

endmodule : dix_irq_expander

// *** verification/dix_irq_expander_assertions.sv ***
/*
 * Holds the concurrent checks on the interrupt expansion block's ports.
 * Assumes one clock domain with an active-high reset, bound to the top.
 */
`timescale 1ns/1ps

module dix_irq_expander_assertions
    import dix_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wdog_expire,
    input wire dix_bus_t bus,
    input wire dix_soft_t soft_req,
    input wire logic emu_trap_sel,
    input wire logic gm_set,
    input wire logic gm_clear,
    input wire dix_ack_t core_ack,
    input wire logic cpu_reset_r,
    input wire logic [5:0] cpu_int_r,
    input wire dix_branch_t branch_r,
    input wire logic global_mask_bit_r
);

    // Illegal access and watchdog both outrank the instructions.
    logic quiet;
    assign quiet = !bus.rd && !bus.wr && !wdog_expire;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_WDOG_RESET:
    assert property (wdog_expire |=> cpu_reset_r && global_mask_bit_r)
        else $error("watchdog expiry gave no reset");
    AST_RESET_BLOCKS:
    assert property (cpu_reset_r |-> cpu_int_r == 6'h00 && global_mask_bit_r)
        else $error("interrupt passed during reset");
    AST_MASK_GATES:
    assert property (global_mask_bit_r && $past(global_mask_bit_r)
        |-> cpu_int_r == 6'h00)
        else $error("interrupt passed a set global mask");
    AST_SOFT_VECTOR_INSTRUCTION_BRANCH:
    assert property (quiet && soft_req.soft_vector_instruction && !soft_req.nmi && !soft_req.trap
        |=> branch_r.req && branch_r.vec == $past(soft_req.vec)
        && global_mask_bit_r)
        else $error("soft vector branch wrong");
    AST_NMI_BRANCH:
    assert property (quiet && soft_req.nmi && !soft_req.trap
        |=> branch_r.req && branch_r.vec == 6'h24 && global_mask_bit_r)
        else $error("nonmaskable branch wrong");
    AST_NO_PIN_NMI:
    assert property (branch_r.req |-> $past(soft_req.soft_vector_instruction || soft_req.nmi
        || soft_req.trap || bus.rd || bus.wr))
        else $error("branch without software or bus cause");
    AST_TRAP_BRANCH:
    assert property (quiet && soft_req.trap |=> branch_r.req
        && branch_r.vec == ($past(emu_trap_sel) ? 6'h26 : 6'h22))
        else $error("trap branch vector wrong");
    AST_TRAP_MASK:
    assert property (quiet && soft_req.trap && !gm_set && !gm_clear
        && !core_ack.valid |=> $stable(global_mask_bit_r))
        else $error("trap changed the global mask");
    AST_ILLEGAL_NMI:
    assert property ((bus.rd || bus.wr) && bus.addr >= 16'h7800
        && !wdog_expire |=> branch_r.req && branch_r.vec == 6'h24)
        else $error("illegal access gave no nonmaskable branch");
    AST_RESERVED_QUIET:
    assert property ((bus.rd || bus.wr) && bus.addr inside {[16'h0100:16'h04ff]}
        && !soft_req.soft_vector_instruction && !soft_req.nmi && !soft_req.trap |=> !branch_r.req)
        else $error("reserved access raised a branch");

endmodule : dix_irq_expander_assertions

bind dix_irq_expander dix_irq_expander_assertions u_dix_irq_expander_assertions (
    .clk(clk), .rst(rst), .wdog_expire(wdog_expire), .bus(bus),
    .soft_req(soft_req), .emu_trap_sel(emu_trap_sel), .gm_set(gm_set),
    .gm_clear(gm_clear), .core_ack(core_ack), .cpu_reset_r(cpu_reset_r),
    .cpu_int_r(cpu_int_r), .branch_r(branch_r),
    .global_mask_bit_r(global_mask_bit_r)
);

// *** verification/dix_core_model.sv ***
/*
 * Holds a behavioural model of the core's interrupt acknowledge logic.
 * Assumes the block's core lines are registered on the rising edge of clk.
 */
`timescale 1ns/1ps

module dix_core_model
    import dix_pkg::*;
(
    input wire logic clk,
    input wire logic ack_en,
    input wire logic [3:0] slow,
    input wire logic [5:0] cpu_int_r,
    output dix_ack_t core_ack
);

    logic [2:0] line_pick;

    // The core takes the lowest line first, after a chosen latency.
    initial
    begin
        core_ack = '0;
        forever
        begin
            @(negedge clk);
            if (ack_en && cpu_int_r != 6'h00)
            begin
                repeat (slow) @(negedge clk);
                line_pick = 3'h0;
                for (int i = 5; i >= 0; i--)
                    if (cpu_int_r[i])
                        line_pick = 3'(i + 1);
                if (line_pick != 3'h0)
                begin
                    core_ack <= '{valid: 1'b1, line: line_pick};
                    @(negedge clk);
                    // The line field is left scrambled while no ack stands.
                    core_ack <= '{valid: 1'b0, line: ~line_pick};
                    repeat (4) @(negedge clk);
                end
            end
        end
    end

endmodule : dix_core_model

// *** verification/dix_irq_expander_tb.sv ***
/*
 * Holds the self-checking testbench of the interrupt expansion block.
 * Assumes the core model answers acknowledges while ack_en is high.
 */
`timescale 1ns/1ps
`include "dix_map.svh"

module dix_irq_expander_tb;
    import dix_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wdog_expire = 1'b0;
    dix_bus_t bus = '0;
    dix_soft_t soft_req = '0;
    logic emu_trap_sel = 1'b0;
    logic gm_set = 1'b0;
    logic gm_clear = 1'b0;
    dix_ack_t core_ack;
    logic pf_pin = 1'b0;
    logic ext_a = 1'b0;
    logic ext_b = 1'b0;
    dix_periph_t periph = '0;
    logic [15:0] bus_rdata_r;
    logic cpu_reset_r;
    logic [5:0] core_line_r;
    logic [5:0] cpu_int_r;
    dix_branch_t branch_r;
    logic global_mask_bit_r;
    logic ack_en = 1'b0;
    logic [3:0] slow = 4'h2;
    int err_count = 0;
    int checks_done = 0;

    always #2.5 clk = ~clk;

    dix_irq_expander u_dix_irq_expander (
        .clk(clk), .rst(rst), .wdog_expire(wdog_expire), .bus(bus),
        .bus_rdata_r(bus_rdata_r), .soft_req(soft_req),
        .emu_trap_sel(emu_trap_sel), .gm_set(gm_set), .gm_clear(gm_clear),
        .core_ack(core_ack), .power_fault_input(pf_pin),
        .external_request_a(ext_a), .external_request_b(ext_b),
        .periph(periph), .cpu_reset_r(cpu_reset_r), .core_line_r(core_line_r),
        .cpu_int_r(cpu_int_r), .branch_r(branch_r),
        .global_mask_bit_r(global_mask_bit_r)
    );

    dix_core_model u_dix_core_model (
        .clk(clk), .ack_en(ack_en), .slow(slow), .cpu_int_r(cpu_int_r),
        .core_ack(core_ack)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // Each driver task lets an edge pass first, so that back to back calls
    // never release and raise the same signal in one time step.
    task automatic bus_write(logic [15:0] a, logic [15:0] d);
        @(negedge clk);
        bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk);
        bus <= '0;
    endtask : bus_write

    // Read data lands at the edge that takes the strobe.
    task automatic bus_read(logic [15:0] a, output logic [15:0] d);
        @(negedge clk);
        bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge clk);
        bus <= '0;
        d = bus_rdata_r;
    endtask : bus_read

    task automatic soft_pulse(dix_soft_t s, logic [5:0] vec, logic gm);
        @(negedge clk);
        soft_req <= s;
        @(negedge clk);
        soft_req <= '0;
        check("branch req", 16'(branch_r.req), 16'h0001);
        check("branch vec", 16'(branch_r.vec), 16'(vec));
        check("global mask", 16'(global_mask_bit_r), 16'(gm));
    endtask : soft_pulse

    task automatic wait_line(int idx, logic lvl);
        int n;
        n = 0;
        while (core_line_r[idx] !== lvl && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        check("line wait", 16'(n < 40), 16'h0001);
    endtask : wait_line

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [15:0] d;
        check("reset out", 16'(cpu_reset_r), 16'h0000);
        check("mask after reset", 16'(global_mask_bit_r), 16'h0001);
        bus_read(`DIX_ADDR_MASK, d);
        check("core mask", d, 16'h0000);
        bus_read(`DIX_ADDR_FLAGS, d);
        check("core flags", d, 16'h0000);
    endtask : t_reset

    task automatic t_soft();
        gm_clear <= 1'b1;
        @(negedge clk);
        gm_clear <= 1'b0;
        soft_pulse('{trap: 1'b1, default: '0}, 6'h22, 1'b0);
        emu_trap_sel <= 1'b1;
        soft_pulse('{trap: 1'b1, default: '0}, 6'h26, 1'b0);
        emu_trap_sel <= 1'b0;
        soft_pulse('{soft_vector_instruction: 1'b1, vec: 6'h0a, default: '0}, 6'h0a, 1'b1);
        soft_pulse('{nmi: 1'b1, default: '0}, 6'h24, 1'b1);
    endtask : t_soft

    // Each source is pended, acknowledged by the core, then vectored.
    task automatic t_event(dix_periph_t p, logic pin, int idx,
                           logic [15:0] vec);
        logic [15:0] d;
        gm_clear <= 1'b1;
        periph <= p;
        pf_pin <= pin;
        @(negedge clk);
        gm_clear <= 1'b0;
        periph <= '0;
        wait_line(idx, 1'b1);
        bus_read(`DIX_ADDR_FLAGS, d);
        check("flag bit", 16'(d[idx]), 16'h0001);
        check("cpu int", 16'(cpu_int_r[idx]), 16'h0001);
        ack_en <= 1'b1;
        wait_line(idx, 1'b0);
        ack_en <= 1'b0;
        pf_pin <= 1'b0;
        bus_read(`DIX_ADDR_VEC, d);
        check("vector", d, vec);
        check("mask after ack", 16'(global_mask_bit_r), 16'h0001);
        repeat (8) @(negedge clk);
    endtask : t_event

    task automatic t_hw();
        bus_write(`DIX_ADDR_MASK, 16'h003f);
        bus_write(`DIX_ADDR_EN0, 16'h0000);
        periph <= '{cmp: 3'h1, default: '0};
        @(negedge clk);
        periph <= '0;
        repeat (4) @(negedge clk);
        check("disabled line", 16'(core_line_r), 16'h0000);
        bus_write(`DIX_ADDR_EN0, 16'hffff);
        bus_write(`DIX_ADDR_EN1, 16'hffff);
        t_event('{cmp: 3'h1, default: '0}, 1'b0, 1, 16'h0021);
        t_event('{tmr_a: 4'h1, default: '0}, 1'b0, 1, 16'h0027);
        t_event('{tmr_b: 4'h1, default: '0}, 1'b0, 2, 16'h002b);
        t_event('0, 1'b1, 0, 16'h0020);
        bus_write(`DIX_ADDR_MODE, 16'h0002);
        t_event('{rx: 1'b1, default: '0}, 1'b0, 4, 16'h0006);
    endtask : t_hw

    // Low-mode converter and pin requests land on line six; a masked
    // line stays off the core although its group pends.
    task automatic t_pins();
        bus_write(`DIX_ADDR_MODE, 16'h0005);
        t_event('{conv: 1'b1, default: '0}, 1'b0, 5, 16'h0004);
        ext_a <= 1'b1;
        t_event('0, 1'b0, 5, 16'h0001);
        ext_a <= 1'b0;
        bus_write(`DIX_ADDR_MASK, 16'h001f);
        gm_clear <= 1'b1;
        ext_b <= 1'b1;
        wait_line(5, 1'b1);
        check("masked line", 16'(cpu_int_r), 16'h0000);
        gm_clear <= 1'b0;
        ext_b <= 1'b0;
    endtask : t_pins

    task automatic t_access();
        logic [15:0] d;
        bus_read(16'h0100, d);
        check("reserved branch", 16'(branch_r.req), 16'h0000);
        bus_read(16'h7800, d);
        check("illegal data", d, 16'h0000);
        check("illegal branch", 16'(branch_r.req), 16'h0001);
        check("illegal vec", 16'(branch_r.vec), 16'h0024);
    endtask : t_access

    task automatic t_wdog();
        wdog_expire <= 1'b1;
        @(negedge clk);
        wdog_expire <= 1'b0;
        check("wdog reset", 16'(cpu_reset_r), 16'h0001);
        check("wdog mask", 16'(global_mask_bit_r), 16'h0001);
        @(negedge clk);
        check("wdog release", 16'(cpu_reset_r), 16'h0000);
    endtask : t_wdog

    // ------------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_soft();
        t_hw();
        t_pins();
        t_access();
        t_wdog();
        test_done();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end

endmodule : dix_irq_expander_tb
